// File: rtl/acrd_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ACRD_MAP_SVH
`define ACRD_MAP_SVH

`define ACRD_ADDR_RATE 8'h5b
`define ACRD_ADDR_BRH 8'h5c
`define ACRD_ADDR_BRL 8'h5d
`define ACRD_ADDR_STAT 8'h5e

`define ACRD_RST_RATE 8'h00
`define ACRD_RST_BRH 8'h00
`define ACRD_RST_BRL 8'h00
`define ACRD_RST_STAT 8'h00

`define ACRD_FS_LSB 4
`define ACRD_ST_HALT 6
`define ACRD_ST_PLL 5
`define ACRD_ST_MISS 4
`define ACRD_ST_AUTO 3
`define ACRD_ST_MCLK 2
`define ACRD_ST_SCLK 1
`define ACRD_ST_FS 0

`define ACRD_CLK_MHZ 100
`define ACRD_MCLK_TMO_NS 1000
`define ACRD_MCLK_TMO_CYC ((`ACRD_MCLK_TMO_NS * `ACRD_CLK_MHZ + 999) / 1000)
`define ACRD_FRAME_TMO_US 250
`define ACRD_FRAME_TMO_CYC (`ACRD_FRAME_TMO_US * `ACRD_CLK_MHZ)

// Core cycles per frame accepted for each rate band at the core rate.
`define ACRD_FS8_MIN 16'h2e81
`define ACRD_FS8_MAX 16'h3366
`define ACRD_FS16_MIN 16'h1740
`define ACRD_FS16_MAX 16'h19b3
`define ACRD_FS48_MIN 16'h07c0
`define ACRD_FS48_MAX 16'h0cda
`define ACRD_FS96_MIN 16'h03e0
`define ACRD_FS96_MAX 16'h04a6
`define ACRD_FS192_MIN 16'h01f0
`define ACRD_FS192_MAX 16'h0253
`define ACRD_FS384_MIN 16'h00f8
`define ACRD_FS384_MAX 16'h0112

`define ACRD_RATIO_LIST {13'h0c00, 13'h0800, 13'h0600, 13'h0480, \
   13'h0400, 13'h0300, 13'h0200, 13'h0180, 13'h0100, 13'h00c0, \
   13'h0080, 13'h0040, 13'h0030, 13'h0020}
`define ACRD_MIN_RATIO_NOPLL 13'h0080
`define ACRD_SCLK_MIN 10'h020
`define ACRD_SCLK_MAX 10'h100

`endif

// File: rtl/acrd_pkg.sv
// Types shared by the audio clock ratio detector modules.
package acrd_pkg;

   typedef enum logic [2:0] {
      FS_ERR = 3'b000,
      FS_8K = 3'b001,
      FS_16K = 3'b010,
      FS_48K = 3'b011,
      FS_96K = 3'b100,
      FS_192K = 3'b101,
      FS_384K = 3'b110
   } acrd_fs_t;

   typedef enum logic {
      PH_IDLE = 1'b0,
      PH_RUN = 1'b1
   } acrd_ph_t;

   typedef struct packed {
      logic [15:0] cyc;
      logic [9:0] sclk;
      logic [12:0] mclk;
      logic sclk_stable;
      logic frame_ok;
      logic lrclk_lost;
      logic sclk_lost;
      logic mclk_lost;
      logic upd;
   } acrd_meas_t;

   typedef struct packed {
      acrd_fs_t fs;
      logic [3:0] ratio;
      logic [8:0] bitclk;
      logic [6:0] stat;
      logic clk_err;
      logic rsv91;
      logic [6:0] rsv92;
      logic rsv94;
      logic [7:0] rdata;
      logic ack;
   } acrd_st_t;

endpackage : acrd_pkg

// File: rtl/acrd_meas.sv
// Frame measurement: synchronises the audio clocks and counts per frame.
`timescale 1ns/100ps
`include "acrd_map.svh"
module acrd_meas #(
   parameter logic [15:0] FRAME_TMO_CYC = 16'(`ACRD_FRAME_TMO_CYC)
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_mclk,
   input wire logic i_sclk,
   input wire logic i_lrclk,
   output acrd_pkg::acrd_meas_t o_meas
);
   import acrd_pkg::*;

   localparam logic [7:0] MCLK_TMO = 8'(`ACRD_MCLK_TMO_CYC);

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] p;
      acrd_ph_t ph;
      logic [15:0] cyc;
      logic [9:0] sclk;
      logic [12:0] mclk;
      logic [15:0] sidle;
      logic [7:0] midle;
      acrd_meas_t m;
   } acrd_mst_t;

   acrd_mst_t q;
   acrd_mst_t d;
   logic [2:0] rise;

   // Edges are seen on the second stage only, so a clock must stay below
   // half the core rate to be counted exactly.
   assign rise = q.s2 & ~q.p;

   always_comb begin
      d = q;
      d.s1 = {i_lrclk, i_sclk, i_mclk};
      d.s2 = q.s1;
      d.p = q.s2;
      d.m.upd = 1'b0;
      if (rise[0]) begin
         d.midle = 8'h00;
      end else if (q.midle != 8'hff) begin
         d.midle = q.midle + 8'h01;
      end
      d.m.mclk_lost = (q.midle >= MCLK_TMO);
      if (rise[1] | rise[2]) begin
         d.sidle = 16'h0000;
      end else if (q.sidle != 16'hffff) begin
         d.sidle = q.sidle + 16'h0001;
      end
      d.m.sclk_lost = (q.sidle >= FRAME_TMO_CYC);
      case (q.ph)
         PH_IDLE: begin
            if (rise[2]) begin
               d.ph = PH_RUN;
               d.cyc = 16'h0001;
               d.sclk = {9'h000, rise[1]};
               d.mclk = {12'h000, rise[0]};
               d.m.lrclk_lost = 1'b0;
            end
         end
         PH_RUN: begin
            if (rise[2]) begin
               // One frame is rising edge to rising edge of the frame clock.
               d.m.cyc = q.cyc;
               d.m.sclk = q.sclk; // RULE7
               d.m.mclk = q.mclk;
               d.m.sclk_stable = (q.sclk == q.m.sclk);
               d.m.frame_ok = 1'b1;
               d.m.upd = 1'b1;
               d.cyc = 16'h0001;
               d.sclk = {9'h000, rise[1]};
               d.mclk = {12'h000, rise[0]};
            end else if (q.cyc >= FRAME_TMO_CYC) begin
               d.ph = PH_IDLE;
               d.m.frame_ok = 1'b0;
               d.m.lrclk_lost = 1'b1;
            end else begin
               d.cyc = q.cyc + 16'h0001;
               if (rise[1] && q.sclk != 10'h3ff) begin
                  d.sclk = q.sclk + 10'h001;
               end
               if (rise[0] && q.mclk != 13'h1fff) begin
                  d.mclk = q.mclk + 13'h0001;
               end
            end
         end
         default: begin
            d.ph = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
         q.m.lrclk_lost <= 1'b1;
         q.m.sclk_lost <= 1'b1;
         q.m.mclk_lost <= 1'b1;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_meas = q.m;

endmodule : acrd_meas

// File: rtl/acrd_top.sv
// Audio clock ratio detector: rate, ratio and clock status registers.
// Notes on behaviour
// [RULE1] Report sample rate as 3-bit code.
// [RULE2] Report master clock ratio, zero when disallowed.
// [RULE3] Valid ratio may still raise clock error.
// [RULE4] Without PLL, low ratios give clock error.
// [RULE5] Source keeps master clock under 50 MHz.
// [RULE6] Bit-clock ratio: MSB alone, low byte next.
// [RULE7] Bit-clock ratio counts bit clocks per frame.
// [RULE8] Ratio unreliable at one bit clock per frame.
// [RULE9] Status flags master halt and PLL unlocked.
// [RULE10] Flags both clocks missing, auto set invalid.
// [RULE11] Flags bit clock unstable or out of range.
// [RULE12] Rate invalid flag, cleared when errors ignored.
// [RULE13] Fields track live clocks; reads have no effect.
`timescale 1ns/100ps
`include "acrd_map.svh"
module acrd_top #(
   parameter logic [15:0] FRAME_TMO_CYC = 16'(`ACRD_FRAME_TMO_CYC)
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_mclk,
   input wire logic i_sclk,
   input wire logic i_lrclk,
   input wire logic i_pll_en,
   input wire logic i_pll_locked,
   input wire logic i_err_ignore,
   input wire logic i_dac_running,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_clock_error
);
   import acrd_pkg::*;

   localparam logic [13:0][12:0] RATIO_TBL = `ACRD_RATIO_LIST;

   acrd_meas_t meas;
   acrd_st_t q;
   acrd_st_t d;
   logic [13:0] match;
   acrd_fs_t fs_c;
   logic [3:0] ratio_c;
   logic [12:0] ratio_nom;
   logic incompat;
   logic sclk_bad;
   logic [7:0] rd_mux;

   acrd_meas #(
      .FRAME_TMO_CYC(FRAME_TMO_CYC)
   ) u_meas (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_mclk(i_mclk),
      .i_sclk(i_sclk),
      .i_lrclk(i_lrclk),
      .o_meas(meas)
   );

   // A band of about three percent absorbs sampling jitter on the count.
   for (genvar g = 0; g < 14; g++) begin : g_ratio
      logic [12:0] lo;
      logic [12:0] hi;
      assign lo = RATIO_TBL[g] - (RATIO_TBL[g] >> 5) - 13'h0001;
      assign hi = RATIO_TBL[g] + (RATIO_TBL[g] >> 5) + 13'h0001;
      assign match[g] = (meas.mclk >= lo) && (meas.mclk <= hi);
   end

   always_comb begin
      fs_c = FS_ERR;
      if (meas.frame_ok) begin // RULE1
         if (meas.cyc >= `ACRD_FS8_MIN && meas.cyc <= `ACRD_FS8_MAX) begin
            fs_c = FS_8K;
         end else if (meas.cyc >= `ACRD_FS16_MIN &&
                      meas.cyc <= `ACRD_FS16_MAX) begin
            fs_c = FS_16K;
         end else if (meas.cyc >= `ACRD_FS48_MIN &&
                      meas.cyc <= `ACRD_FS48_MAX) begin
            fs_c = FS_48K;
         end else if (meas.cyc >= `ACRD_FS96_MIN &&
                      meas.cyc <= `ACRD_FS96_MAX) begin
            fs_c = FS_96K;
         end else if (meas.cyc >= `ACRD_FS192_MIN &&
                      meas.cyc <= `ACRD_FS192_MAX) begin
            fs_c = FS_192K;
         end else if (meas.cyc >= `ACRD_FS384_MIN &&
                      meas.cyc <= `ACRD_FS384_MAX) begin
            fs_c = FS_384K;
         end
      end
   end

   always_comb begin
      ratio_c = 4'h0;
      ratio_nom = 13'h0000;
      if (meas.frame_ok && !meas.mclk_lost) begin // RULE2
         for (int i = 13; i >= 0; i--) begin
            if (match[i]) begin
               ratio_c = 4'(i + 1);
               ratio_nom = RATIO_TBL[i];
            end
         end
      end
   end

   // The master clock above half the core rate is refused outright; the
   // source must keep it under 50 MHz anyway.
   assign incompat = (ratio_c != 4'h0) && (fs_c != FS_ERR) &&
      (({2'b00, meas.mclk, 1'b0} > meas.cyc) || // RULE3 RULE5
       (!i_pll_en && ratio_nom < `ACRD_MIN_RATIO_NOPLL)); // RULE4
   // A single bit clock per frame falls below the range, so its count is
   // never trusted.
   assign sclk_bad = !meas.frame_ok || !meas.sclk_stable || // RULE11
      meas.sclk < `ACRD_SCLK_MIN || meas.sclk > `ACRD_SCLK_MAX; // RULE8

   always_comb begin
      case (i_reg_addr)
         `ACRD_ADDR_RATE: rd_mux = {q.rsv91, q.fs, q.ratio};
         `ACRD_ADDR_BRH: rd_mux = {q.rsv92, q.bitclk[8]}; // RULE6
         `ACRD_ADDR_BRL: rd_mux = q.bitclk[7:0];
         `ACRD_ADDR_STAT: rd_mux = {q.rsv94, q.stat};
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      d = q;
      d.fs = fs_c; // RULE13
      d.ratio = ratio_c;
      d.bitclk = meas.sclk[9] ? 9'h1ff : meas.sclk[8:0]; // RULE7
      d.stat[`ACRD_ST_HALT] = meas.mclk_lost; // RULE9
      d.stat[`ACRD_ST_PLL] = !i_pll_en || !i_pll_locked;
      d.stat[`ACRD_ST_MISS] = meas.lrclk_lost && meas.sclk_lost; // RULE10
      d.stat[`ACRD_ST_AUTO] = (fs_c == FS_ERR) || (ratio_c == 4'h0) ||
         incompat;
      d.stat[`ACRD_ST_MCLK] = (ratio_c == 4'h0); // RULE11
      d.stat[`ACRD_ST_SCLK] = sclk_bad;
      d.stat[`ACRD_ST_FS] = (fs_c == FS_ERR) &&
         !(i_err_ignore && i_dac_running); // RULE12
      d.clk_err = (fs_c == FS_ERR) || (ratio_c == 4'h0) || incompat ||
         sclk_bad; // RULE3
      d.ack = i_reg_rd || i_reg_wr;
      if (i_reg_rd) begin
         d.rdata = rd_mux; // RULE13
      end
      // Only the reserved bits hold written data; detected fields ignore
      // writes so software cannot disturb them.
      if (i_reg_wr) begin
         case (i_reg_addr)
            `ACRD_ADDR_RATE: d.rsv91 = i_reg_wdata[7];
            `ACRD_ADDR_BRH: d.rsv92 = i_reg_wdata[7:1];
            `ACRD_ADDR_STAT: d.rsv94 = i_reg_wdata[7];
            default: d.rsv91 = q.rsv91;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.rdata;
   assign o_reg_ack = q.ack;
   assign o_clock_error = q.clk_err;

   chk_fs_lost: assert property ( // RULE1
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !meas.frame_ok) |=> (q.fs == FS_ERR))
      else $error("rate code not zero without frames");
   chk_ratio_halt: assert property ( // RULE2
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && meas.mclk_lost) |=> (q.ratio == 4'h0))
      else $error("ratio code not zero with master clock halted");
   chk_err_fast: assert property ( // RULE3
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && ratio_c != 4'h0 && fs_c != FS_ERR &&
       {2'b00, meas.mclk, 1'b0} > meas.cyc) |=> q.clk_err)
      else $error("too fast master clock not flagged");
   chk_err_nopll: assert property ( // RULE4
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && !i_pll_en && ratio_c != 4'h0 && fs_c != FS_ERR &&
       ratio_nom < `ACRD_MIN_RATIO_NOPLL) |=> q.clk_err)
      else $error("low ratio without PLL not flagged");
   chk_msb_read: assert property ( // RULE6
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_reg_rd && i_reg_addr == `ACRD_ADDR_BRH) |=>
      (o_reg_ack && o_reg_rdata[0] == $past(q.bitclk[8])))
      else $error("bit clock ratio MSB read wrong");
   chk_bitclk_cnt: assert property ( // RULE7
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && meas.upd) ##1 i_ce |=>
      (q.bitclk == $past(meas.sclk[8:0], 1) || meas.sclk[9]))
      else $error("bit clock ratio not taken from frame count");
   chk_halt_flag: assert property ( // RULE9
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && meas.mclk_lost) |=> q.stat[`ACRD_ST_HALT])
      else $error("master halt flag missing");
   // The flag only follows the lost bits on edges where the enable let
   // the state move; a frozen flag may legally lag behind.
   chk_miss_flag: assert property ( // RULE10
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (q.stat[`ACRD_ST_MISS] && $past(i_ce)) |->
      $past(meas.lrclk_lost && meas.sclk_lost))
      else $error("missing flag without both clocks lost");
   chk_auto_flag: assert property ( // RULE10
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && fs_c == FS_ERR) |=> q.stat[`ACRD_ST_AUTO])
      else $error("auto set flag missing without a rate");
   chk_sclk_range: assert property ( // RULE11
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && meas.sclk < `ACRD_SCLK_MIN) |=> q.stat[`ACRD_ST_SCLK])
      else $error("short bit clock ratio not flagged");
   chk_fs_flag: assert property ( // RULE12
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ce && i_err_ignore && i_dac_running) |=> !q.stat[`ACRD_ST_FS])
      else $error("rate flag shown while errors ignored");

   cov_fs48: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      q.fs == FS_48K && q.ratio == 4'h6);
   cov_err: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(q.clk_err));
   cov_halt: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(q.stat[`ACRD_ST_HALT]));
   cov_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_reg_rd && i_reg_addr == `ACRD_ADDR_STAT);

endmodule : acrd_top

// File: tb/acrd_src.sv
// Behavioural serial audio source driving master, bit and frame clocks.
`timescale 1ns/100ps
module acrd_src (
   input wire logic i_run_audio,
   input wire logic i_run_mclk,
   input wire logic [15:0] i_mclk_half,
   input wire logic [15:0] i_sclk_half,
   input wire logic [9:0] i_bits,
   output logic o_mclk,
   output logic o_sclk,
   output logic o_lrclk
);
   // Halves are never below 40 ns, so the master clock stays far under
   // 50 MHz and inside what the synchronisers can count.
   always begin
      if (i_run_mclk && i_mclk_half != 16'h0000) begin
         o_mclk = ~o_mclk;
         #(i_mclk_half);
      end else begin
         o_mclk = 1'b0;
         @(i_run_mclk or i_mclk_half);
      end
   end

   // A stopped source ties both clocks low, as a missing source would.
   always begin
      if (i_run_audio && i_bits > 10'h001) begin
         for (int b = 0; b < i_bits; b++) begin
            o_lrclk = (b < i_bits / 2);
            o_sclk = 1'b0;
            #(i_sclk_half);
            o_sclk = 1'b1;
            #(i_sclk_half);
         end
      end else begin
         o_sclk = 1'b0;
         o_lrclk = 1'b0;
         @(i_run_audio or i_bits);
      end
   end
endmodule : acrd_src

// File: tb/tb.sv
// Self-checking bench for the audio clock ratio detector.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; \
   if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic pll_en = 1'b0;
   logic pll_locked = 1'b0;
   logic err_ignore = 1'b0;
   logic dac_running = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_ack;
   logic clock_error;
   logic mclk, sclk, lrclk;
   logic run_audio = 1'b0;
   logic run_mclk = 1'b0;
   logic [15:0] mclk_half = 16'h0028;
   logic [15:0] sclk_half = 16'h0050;
   logic [9:0] bits = 10'h040;
   int n_fail = 0;
   int total_checks = 0;

   always #5 core_clk = ~core_clk;

   acrd_src u_acrd_src (.i_run_audio(run_audio), .i_run_mclk(run_mclk),
      .i_mclk_half(mclk_half), .i_sclk_half(sclk_half), .i_bits(bits),
      .o_mclk(mclk), .o_sclk(sclk), .o_lrclk(lrclk));

   // A short frame timeout keeps the lost-clock scenario brief.
   acrd_top #(.FRAME_TMO_CYC(16'h1000)) u_acrd_top (
      .i_core_clk(core_clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_mclk(mclk), .i_sclk(sclk), .i_lrclk(lrclk),
      .i_pll_en(pll_en), .i_pll_locked(pll_locked),
      .i_err_ignore(err_ignore), .i_dac_running(dac_running),
      .i_reg_addr(reg_addr), .i_reg_rd(reg_rd), .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
      .o_reg_ack(reg_ack), .o_clock_error(clock_error));

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("read ack", 1'b1, reg_ack)
      d = reg_rdata;
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
      `CHK("write ack", 1'b1, reg_ack)
   endtask : wr

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] mask);
      logic [7:0] d;
      rd(a, d);
      `CHK($sformatf("reg %h", a), e & mask, d & mask)
   endtask : expect_reg

   task automatic setup(input logic [15:0] mh, input logic [15:0] sh,
      input logic [9:0] nb);
      @(posedge core_clk);
      mclk_half <= mh;
      sclk_half <= sh;
      bits <= nb;
      run_audio <= 1'b1;
      run_mclk <= 1'b1;
      // Several frames must pass so the bit count is seen as stable.
      repeat (10000) @(posedge core_clk);
   endtask : setup

   // The tests need about 50300 cycles; the margin covers slow settling.
   initial begin
      repeat (80000) @(posedge core_clk);
      n_fail++;
      test_done;
   end

   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      expect_reg(8'h5b, 8'h00, 8'hff);
      expect_reg(8'h5c, 8'h00, 8'hff);
      expect_reg(8'h5d, 8'h00, 8'hff);
      $display("test reset values done");
      @(posedge core_clk);
      pll_en <= 1'b1;
      pll_locked <= 1'b1;
      setup(16'h0028, 16'h0050, 10'h040);
      expect_reg(8'h5b, 8'h44, 8'hff);
      expect_reg(8'h5c, 8'h00, 8'hff);
      expect_reg(8'h5d, 8'h40, 8'hff);
      expect_reg(8'h5e, 8'h00, 8'hff);
      `CHK("clock error", 1'b0, clock_error)
      wr(8'h5b, 8'hff);
      expect_reg(8'h5b, 8'hc4, 8'hff);
      wr(8'h5d, 8'hff);
      expect_reg(8'h5d, 8'h40, 8'hff);
      wr(8'h5b, 8'h00);
      expect_reg(8'h60, 8'h00, 8'hff);
      $display("test 96k 128fs done");
      setup(16'h0028, 16'h0028, 10'h100);
      expect_reg(8'h5b, 8'h36, 8'hff);
      expect_reg(8'h5c, 8'h01, 8'hff);
      expect_reg(8'h5d, 8'h00, 8'hff);
      expect_reg(8'h5e, 8'h00, 8'hff);
      wr(8'h5c, 8'hfe);
      expect_reg(8'h5c, 8'hff, 8'hff);
      wr(8'h5c, 8'h00);
      $display("test 48k 256fs done");
      // Sixteen bit clocks per frame lie below the valid ratio range.
      setup(16'h0028, 16'h0050, 10'h010);
      expect_reg(8'h5b, 8'h61, 8'hff);
      expect_reg(8'h5d, 8'h10, 8'hff);
      expect_reg(8'h5e, 8'h02, 8'hff);
      `CHK("clock error", 1'b1, clock_error)
      $display("test short bit clock done");
      @(posedge core_clk);
      pll_en <= 1'b0;
      setup(16'h0050, 16'h0050, 10'h040);
      expect_reg(8'h5b, 8'h43, 8'hff);
      expect_reg(8'h5e, 8'h28, 8'hff);
      `CHK("clock error", 1'b1, clock_error)
      @(posedge core_clk);
      pll_en <= 1'b1;
      pll_locked <= 1'b0;
      repeat (20) @(posedge core_clk);
      expect_reg(8'h5e, 8'h20, 8'hff);
      `CHK("clock error", 1'b0, clock_error)
      // With the enable low a PLL drop must not reach the error output.
      @(posedge core_clk);
      ce <= 1'b0;
      pll_en <= 1'b0;
      repeat (10) @(posedge core_clk);
      `CHK("frozen clock error", 1'b0, clock_error)
      ce <= 1'b1;
      pll_en <= 1'b1;
      $display("test no pll done");
      pll_locked <= 1'b1;
      run_mclk <= 1'b0;
      repeat (200) @(posedge core_clk);
      expect_reg(8'h5e, 8'h40, 8'h40);
      @(posedge core_clk);
      run_audio <= 1'b0;
      repeat (10000) @(posedge core_clk);
      expect_reg(8'h5e, 8'h5f, 8'hff);
      expect_reg(8'h5b, 8'h00, 8'hff);
      `CHK("clock error", 1'b1, clock_error)
      @(posedge core_clk);
      err_ignore <= 1'b1;
      dac_running <= 1'b1;
      repeat (5) @(posedge core_clk);
      expect_reg(8'h5e, 8'h5e, 8'hff);
      $display("test lost clocks done");
      test_done;
   end
endmodule : tb
